// File: src/dsclk_pkg.sv
// Package of offsets, field positions, reset values and counts for the lane setup block.
package dsclk_pkg;

  // ************************************************************
  // Register offsets (byte addresses on the register bus)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PIX_KHZ   = 8'h04;
  localparam logic [7:0] OFS_LANE_KHZ  = 8'h08;
  localparam logic [7:0] OFS_LINK_KHZ  = 8'h0C;
  localparam logic [7:0] OFS_VID_KHZ   = 8'h10;
  localparam logic [7:0] OFS_LANE_STAT = 8'h14;
  localparam logic [7:0] OFS_AUDIO     = 8'h18;
  localparam logic [7:0] OFS_TWM_CMD   = 8'h1C;
  localparam logic [7:0] OFS_TWM_STAT  = 8'h20;

  // ************************************************************
  // Control register fields and reset values
  // ************************************************************
  localparam int CTRL_FIXED_BIT  = 0;
  localparam int CTRL_RATE_LSB   = 1;
  localparam int CTRL_DEPTH_LSB  = 4;
  localparam int CTRL_FMT_LSB    = 6;
  localparam int CTRL_VRST_BIT   = 8;
  localparam logic [8:0]  CTRL_RESET    = 9'h000;
  localparam logic [19:0] PIX_KHZ_RESET = 20'h00000;

  // ************************************************************
  // Two-wire command and status fields
  // ************************************************************
  localparam int TWM_WDATA_LSB = 0;
  localparam int TWM_REG_LSB   = 8;
  localparam int TWM_DEV_LSB   = 16;
  localparam int TWM_RD_BIT    = 23;
  localparam int TWM_GO_BIT    = 24;
  localparam int TWS_BUSY_BIT  = 0;
  localparam int TWS_NACK_BIT  = 1;
  localparam int TWS_DONE_BIT  = 2;
  localparam int TWS_RDATA_LSB = 8;

  // ************************************************************
  // Clock relations and lane usage
  // ************************************************************
  localparam logic [1:0]  FMT_YCC420     = 2'h3;
  localparam int          CHAR_BITS      = 10;
  localparam int          LINK_DIVIDER   = 20;
  localparam logic [31:0] VID_FIXED_KHZ  = 32'h00036EE8;
  localparam int          LANE_COUNT     = 4;
  localparam int          LANE_BITS      = 10;
  localparam logic [3:0]  LANES_ALL      = 4'hF;
  localparam logic [3:0]  LANES_THREE    = 4'h7;
  localparam logic [3:0]  LANES_NONE     = 4'h0;

  // ************************************************************
  // Two-wire bus timing: quarter of a 100 kHz bit period
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TWM_QUARTER_NS  = 2500;
  localparam int TWM_QUARTER_CYC = (TWM_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Two-wire master states.
  typedef enum logic [3:0] {
    TWM_IDLE  = 4'b0001,
    TWM_START = 4'b0010,
    TWM_BYTE  = 4'b0100,
    TWM_STOP  = 4'b1000
  } dsclk_twm_state_t;

endpackage

// File: src/dsclk_twm_if.sv
// Interface that carries commands and status between the top and the two-wire master.
`timescale 1ns/1ps
interface dsclk_twm_if;
  logic       go;
  logic       rd;
  logic [6:0] dev;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic       busy;
  logic       nack;
  logic       done;
  logic [7:0] rdata;

  modport ctl (output go, rd, dev, reg_addr, wdata, input busy, nack, done, rdata);
  modport master (input go, rd, dev, reg_addr, wdata, output busy, nack, done, rdata);
endinterface

// File: src/dsclk_twm_master.sv
// Two-wire master that writes or reads one register of the sink over the data channel.
`timescale 1ns/1ps
module dsclk_twm_master #(
  parameter int QUARTER = dsclk_pkg::TWM_QUARTER_CYC
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  dsclk_twm_if.master    cmd,
  input  wire logic      sda_i,
  output logic           scl_oe_o,
  output logic           sda_oe_o
);

  dsclk_pkg::dsclk_twm_state_t state;
  logic [15:0] qcnt;
  logic        tick;
  logic [1:0]  ph;
  logic [3:0]  bit_cnt;
  logic [1:0]  bidx;
  logic [7:0]  shreg;
  logic        rd_mode;
  logic [6:0]  dev;
  logic [7:0]  reg_addr;
  logic [7:0]  wdata;
  logic        scl_lvl;
  logic        sda_lvl;

  // Picks the byte sent in each slot of a transfer; slot 3 is the read byte.
  function automatic logic [7:0] byte_for(input logic [1:0] idx);
    case (idx)
      2'h0:    byte_for = {dev, 1'b0};
      2'h1:    byte_for = reg_addr;
      2'h2:    byte_for = rd_mode ? {dev, 1'b1} : wdata;
      default: byte_for = 8'hFF;
    endcase
  endfunction

  // Quarter bit timer, held at zero while idle.
  always_ff @(posedge clk_i) begin
    if (rst_i || state == dsclk_pkg::TWM_IDLE || tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end
  assign tick = (qcnt == 16'(QUARTER - 1));

  // Sequencer for start, bytes with acknowledge, repeated start and stop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= dsclk_pkg::TWM_IDLE;
      ph        <= 2'h0;
      bit_cnt   <= 4'h0;
      bidx      <= 2'h0;
      shreg     <= 8'h00;
      rd_mode   <= 1'b0;
      dev       <= 7'h00;
      reg_addr  <= 8'h00;
      wdata     <= 8'h00;
      scl_lvl   <= 1'b1;
      sda_lvl   <= 1'b1;
      cmd.nack  <= 1'b0;
      cmd.done  <= 1'b0;
      cmd.rdata <= 8'h00;
    end else begin
      cmd.done <= 1'b0;
      if (state == dsclk_pkg::TWM_IDLE) begin
        if (cmd.go) begin
          rd_mode  <= cmd.rd;
          dev      <= cmd.dev;
          reg_addr <= cmd.reg_addr;
          wdata    <= cmd.wdata;
          cmd.nack <= 1'b0;
          bidx     <= 2'h0;
          ph       <= 2'h0;
          state    <= dsclk_pkg::TWM_START;
        end
      end else if (tick) begin
        ph <= ph + 2'h1;
        case (state)
          dsclk_pkg::TWM_START: begin
            case (ph)
              2'h0:    begin scl_lvl <= 1'b0; sda_lvl <= 1'b1; end
              2'h1:    scl_lvl <= 1'b1;
              2'h2:    sda_lvl <= 1'b0;
              default: begin
                scl_lvl <= 1'b0;
                bit_cnt <= 4'h0;
                shreg   <= byte_for(bidx);
                state   <= dsclk_pkg::TWM_BYTE;
              end
            endcase
          end
          dsclk_pkg::TWM_BYTE: begin
            case (ph)
              2'h0: begin
                scl_lvl <= 1'b0;
                // Acknowledge slot is released; the read byte ends with a refusal.
                sda_lvl <= (bit_cnt == 4'h8 || bidx == 2'h3) ? 1'b1 : shreg[7];
              end
              2'h1: scl_lvl <= 1'b1;
              2'h2: begin
                if (bit_cnt != 4'h8 && bidx == 2'h3) begin
                  cmd.rdata <= {cmd.rdata[6:0], sda_i};
                end
                if (bit_cnt == 4'h8 && bidx != 2'h3 && sda_i) begin
                  cmd.nack <= 1'b1;
                end
              end
              default: begin
                scl_lvl <= 1'b0;
                if (bit_cnt != 4'h8) begin
                  shreg   <= {shreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
                end else if (cmd.nack || bidx == 2'h3 || (!rd_mode && bidx == 2'h2)) begin
                  state <= dsclk_pkg::TWM_STOP;
                end else if (rd_mode && bidx == 2'h1) begin
                  bidx  <= 2'h2;
                  state <= dsclk_pkg::TWM_START;
                end else begin
                  bidx    <= bidx + 2'h1;
                  bit_cnt <= 4'h0;
                  shreg   <= byte_for(bidx + 2'h1);
                end
              end
            endcase
          end
          dsclk_pkg::TWM_STOP: begin
            case (ph)
              2'h0:    begin scl_lvl <= 1'b0; sda_lvl <= 1'b0; end
              2'h1:    scl_lvl <= 1'b1;
              2'h2:    sda_lvl <= 1'b1;
              default: begin
                cmd.done <= 1'b1;
                state    <= dsclk_pkg::TWM_IDLE;
              end
            endcase
          end
          default: state <= dsclk_pkg::TWM_IDLE;
        endcase
      end
    end
  end

  // Open-drain drive: the pin is pulled low only while its level is zero.
  assign scl_oe_o = ~scl_lvl;
  assign sda_oe_o = ~sda_lvl;
  assign cmd.busy = (state != dsclk_pkg::TWM_IDLE);

endmodule

// File: src/dsclk_lane_setup.sv
// Clock, reset and lane usage front end of the display link transmitter with its register file.
//
// Notes on behaviour
// - Main reset quiets the lane outputs at once, without clock; registers clear on the clock edge.
// - Video reset input only without fixed-rate option.
// - Four channel outputs leave on link clock.
// - Lane rate is pixel times ten times ratio.
// - Fixed-rate mode accepts only qualified video words.
// - Four lanes; fixed rates 1-2 use three, rates 0 and 7 none.
// - Optional two-wire master reaches sink data.
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module dsclk_lane_setup #(
  parameter bit FIXED_RATE_OPTION = 1'b0,
  parameter bit TWO_WIRE_OPTION   = 1'b1,
  parameter int XCVR_WIDTH        = 20,
  parameter int VIDEO_BITS        = 48,
  parameter int AUDIO_BITS        = 32
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic                         wb_ack_o,
  input  wire logic                    video_domain_reset_i,
  input  wire logic [39:0]             lane_word_i,
  output logic      [9:0]              clock_channel_out_o,
  output logic      [9:0]              red_channel_out_o,
  output logic      [9:0]              green_channel_out_o,
  output logic      [9:0]              blue_channel_out_o,
  output logic      [3:0]              lane_active_o,
  input  wire logic [VIDEO_BITS-1:0]   video_word_i,
  input  wire logic                    video_word_valid_i,
  output logic      [VIDEO_BITS-1:0]   video_word_o,
  output logic                         video_word_strobe_o,
  input  wire logic [AUDIO_BITS-1:0]   audio_sample_word_i,
  input  wire logic                    audio_data_qualifier_i,
  output logic      [AUDIO_BITS-1:0]   audio_sample_o,
  output logic                         audio_sample_strobe_o,
  input  wire logic                    ddc_scl_i,
  output logic                         ddc_scl_o,
  output logic                         ddc_scl_oe_o,
  input  wire logic                    ddc_sda_i,
  output logic                         ddc_sda_o,
  output logic                         ddc_sda_oe_o
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Colour depth ratio in quarters: 8, 10, 12 and 16 bits per component.
  function automatic logic [3:0] ratio_q(input logic [1:0] depth);
    case (depth)
      2'h0:    ratio_q = 4'h4;
      2'h1:    ratio_q = 4'h5;
      2'h2:    ratio_q = 4'h6;
      default: ratio_q = 4'h8;
    endcase
  endfunction

  // Lanes that carry data for the mode and fixed-rate link rate.
  function automatic logic [3:0] lanes_for(input logic fixed, input logic [2:0] rate);
    if (!fixed) begin
      lanes_for = dsclk_pkg::LANES_ALL;
    end else if (rate == 3'h1 || rate == 3'h2) begin
      lanes_for = dsclk_pkg::LANES_THREE;
    end else if (rate >= 3'h3 && rate <= 3'h6) begin
      lanes_for = dsclk_pkg::LANES_ALL;
    end else begin
      lanes_for = dsclk_pkg::LANES_NONE;
    end
  endfunction

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // ************************************************************
  // Register bus slave
  // ************************************************************
  logic [8:0]            ctrl;
  logic [19:0]           pix_khz;
  logic [31:0]           lane_khz;
  logic [31:0]           link_khz;
  logic [31:0]           vid_khz;
  logic [15:0]           audio_count;
  logic [24:0]           twm_cmd;
  logic                  twm_done_flag;
  logic                  wr_take;
  logic                  fixed_mode;
  logic [2:0]            rate;
  logic [1:0]            depth;
  logic [1:0]            fmt;
  logic                  vid_rst;
  logic [3:0]            lanes;
  logic [39:0]           lane_q;
  logic [31:0]           next_ctrl;
  logic [31:0]           next_pix;
  logic [31:0]           next_cmd;
  dsclk_twm_if           twm ();

  assign wr_take    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign fixed_mode = FIXED_RATE_OPTION && ctrl[dsclk_pkg::CTRL_FIXED_BIT];
  assign rate       = ctrl[dsclk_pkg::CTRL_RATE_LSB +: 3];
  assign depth      = ctrl[dsclk_pkg::CTRL_DEPTH_LSB +: 2];
  assign fmt        = ctrl[dsclk_pkg::CTRL_FMT_LSB +: 2];
  assign next_ctrl  = merge({23'h000000, ctrl}, wb_dat_i, wb_sel_i);
  assign next_pix   = merge({12'h000, pix_khz}, wb_dat_i, wb_sel_i);
  assign next_cmd   = merge({7'h00, twm_cmd}, wb_dat_i, wb_sel_i);

  // Answers every access one cycle after it is raised and drops in the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Writable registers take their data at the edge where the master sees the answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= dsclk_pkg::CTRL_RESET;
      pix_khz <= dsclk_pkg::PIX_KHZ_RESET;
      twm_cmd <= 25'h0000000;
    end else if (wr_take) begin
      case (wb_adr_i)
        dsclk_pkg::OFS_CTRL:    ctrl    <= next_ctrl[8:0];
        dsclk_pkg::OFS_PIX_KHZ: pix_khz <= next_pix[19:0];
        dsclk_pkg::OFS_TWM_CMD: twm_cmd <= {1'b0, next_cmd[23:0]};
        default:                ctrl    <= ctrl;
      endcase
    end
  end

  // A command write with the go bit set starts one two-wire transfer while the master is not busy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      twm.go <= 1'b0;
    end else begin
      twm.go <= wr_take && wb_adr_i == dsclk_pkg::OFS_TWM_CMD && wb_sel_i[3]
                && wb_dat_i[dsclk_pkg::TWM_GO_BIT] && !twm.busy;
    end
  end
  assign twm.rd       = twm_cmd[dsclk_pkg::TWM_RD_BIT];
  assign twm.dev      = twm_cmd[dsclk_pkg::TWM_DEV_LSB +: 7];
  assign twm.reg_addr = twm_cmd[dsclk_pkg::TWM_REG_LSB +: 8];
  assign twm.wdata    = twm_cmd[dsclk_pkg::TWM_WDATA_LSB +: 8];

  // Sticky done flag; a finishing transfer wins over a clear by writing one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      twm_done_flag <= 1'b0;
    end else if (twm.done) begin
      twm_done_flag <= 1'b1;
    end else if (wr_take && wb_adr_i == dsclk_pkg::OFS_TWM_STAT && wb_sel_i[0]
                 && wb_dat_i[dsclk_pkg::TWS_DONE_BIT]) begin
      twm_done_flag <= 1'b0;
    end
  end

  // Read data is latched together with the answer; unmapped offsets read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        dsclk_pkg::OFS_CTRL:      wb_dat_o <= {23'h000000, ctrl};
        dsclk_pkg::OFS_PIX_KHZ:   wb_dat_o <= {12'h000, pix_khz};
        dsclk_pkg::OFS_LANE_KHZ:  wb_dat_o <= lane_khz;
        dsclk_pkg::OFS_LINK_KHZ:  wb_dat_o <= link_khz;
        dsclk_pkg::OFS_VID_KHZ:   wb_dat_o <= vid_khz;
        dsclk_pkg::OFS_LANE_STAT: wb_dat_o <= {audio_count, 12'h000, lanes};
        dsclk_pkg::OFS_AUDIO:     wb_dat_o <= 32'(audio_sample_o);
        dsclk_pkg::OFS_TWM_CMD:   wb_dat_o <= {7'h00, twm_cmd};
        dsclk_pkg::OFS_TWM_STAT:  wb_dat_o <= {16'h0000, twm.rdata, 5'h00,
                                              twm_done_flag, twm.nack, twm.busy};
        default:                  wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // Clock relations reported to software
  // ************************************************************

  // Lane rate, link clock and video clock in kHz from pixel rate, depth and format.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_khz <= 32'h00000000;
      link_khz <= 32'h00000000;
      vid_khz  <= 32'h00000000;
    end else begin
      lane_khz <= (32'(pix_khz) * 32'(dsclk_pkg::CHAR_BITS) * 32'(ratio_q(depth))) >> 2;
      link_khz <= lane_khz / 32'(dsclk_pkg::LINK_DIVIDER);
      if (fixed_mode) begin
        vid_khz <= dsclk_pkg::VID_FIXED_KHZ;
      end else if (fmt == dsclk_pkg::FMT_YCC420) begin
        vid_khz <= (32'(pix_khz) * 32'(dsclk_pkg::CHAR_BITS) / 32'(XCVR_WIDTH)) >> 1;
      end else begin
        vid_khz <= 32'(pix_khz) * 32'(dsclk_pkg::CHAR_BITS) / 32'(XCVR_WIDTH);
      end
    end
  end

  // ************************************************************
  // Lane outputs
  // ************************************************************
  assign lanes = lanes_for(fixed_mode, rate);

  // Channel words are registered on the link clock; unused lanes carry zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_q <= 40'h0000000000;
    end else begin
      for (int l = 0; l < dsclk_pkg::LANE_COUNT; l++) begin
        lane_q[l*dsclk_pkg::LANE_BITS +: dsclk_pkg::LANE_BITS] <=
          lanes[l] ? lane_word_i[l*dsclk_pkg::LANE_BITS +: dsclk_pkg::LANE_BITS] : 10'h000;
      end
    end
  end

  // Reset forces the lanes quiet at once, without waiting for an edge.
  assign clock_channel_out_o = rst_i ? 10'h000 : lane_q[39:30];
  assign red_channel_out_o   = rst_i ? 10'h000 : lane_q[29:20];
  assign green_channel_out_o = rst_i ? 10'h000 : lane_q[19:10];
  assign blue_channel_out_o  = rst_i ? 10'h000 : lane_q[9:0];
  assign lane_active_o       = rst_i ? 4'h0 : lanes;

  // ************************************************************
  // Video and audio capture
  // ************************************************************

  // The separate video reset, pin or register bit, exists only without the fixed-rate option.
  assign vid_rst = rst_i || (!FIXED_RATE_OPTION && (video_domain_reset_i
                   || ctrl[dsclk_pkg::CTRL_VRST_BIT]));

  // In fixed-rate mode only qualified words pass; otherwise every cycle carries a word.
  always_ff @(posedge clk_i) begin
    if (vid_rst) begin
      video_word_o        <= '0;
      video_word_strobe_o <= 1'b0;
    end else begin
      video_word_strobe_o <= !fixed_mode || video_word_valid_i;
      if (!fixed_mode || video_word_valid_i) begin
        video_word_o <= video_word_i;
      end
    end
  end

  // Audio words are taken only in cycles where the qualifier is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      audio_sample_o        <= '0;
      audio_sample_strobe_o <= 1'b0;
      audio_count           <= 16'h0000;
    end else begin
      audio_sample_strobe_o <= audio_data_qualifier_i;
      if (audio_data_qualifier_i) begin
        audio_sample_o <= audio_sample_word_i;
        audio_count    <= audio_count + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Two-wire master
  // ************************************************************
  assign ddc_scl_o = 1'b0;
  assign ddc_sda_o = 1'b0;

  generate
    if (TWO_WIRE_OPTION) begin : g_twm
      dsclk_twm_master u_twm (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .cmd      (twm.master),
        .sda_i    (ddc_sda_i),
        .scl_oe_o (ddc_scl_oe_o),
        .sda_oe_o (ddc_sda_oe_o)
      );
    end else begin : g_no_twm
      assign twm.busy     = 1'b0;
      assign twm.nack     = 1'b0;
      assign twm.done     = 1'b0;
      assign twm.rdata    = 8'h00;
      assign ddc_scl_oe_o = 1'b0;
      assign ddc_sda_oe_o = 1'b0;
    end
  endgenerate

endmodule

// File: dv/dsclk_lane_setup_chk.sv
// Checker of the lane setup block ports.
`timescale 1ns/1ps
module dsclk_lane_setup_chk #(
  parameter bit FIXED_RATE_OPTION = 1'b0,
  parameter int VIDEO_BITS        = 48,
  parameter int AUDIO_BITS        = 32
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  video_domain_reset_i,
  input wire logic [39:0]           lane_word_i,
  input wire logic [9:0]            clock_channel_out_o,
  input wire logic [9:0]            blue_channel_out_o,
  input wire logic [3:0]            lane_active_o,
  input wire logic [VIDEO_BITS-1:0] video_word_i,
  input wire logic                  video_word_valid_i,
  input wire logic [VIDEO_BITS-1:0] video_word_o,
  input wire logic                  video_word_strobe_o,
  input wire logic [AUDIO_BITS-1:0] audio_sample_word_i,
  input wire logic                  audio_data_qualifier_i,
  input wire logic [AUDIO_BITS-1:0] audio_sample_o,
  input wire logic                  audio_sample_strobe_o,
  input wire logic                  ddc_sda_oe_o
);
  // Every check samples on the one link clock.
  default clocking cb @(posedge clk_i); endclocking
  AST_ACK_NEXT: assert property (disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_ACK_PULSE: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  AST_RST_QUIET: assert property (
    rst_i |-> lane_active_o == 4'h0 && clock_channel_out_o == 10'h000)
    else $error("lanes live in reset");
  AST_ALL_LANES: assert property (disable iff (rst_i)
    !FIXED_RATE_OPTION |-> lane_active_o == 4'hF)
    else $error("lane mask wrong");
  AST_LANE_PIPE: assert property (disable iff (rst_i)
    !$past(rst_i) && lane_active_o == 4'hF |->
    clock_channel_out_o == $past(lane_word_i[39:30]) &&
    blue_channel_out_o == $past(lane_word_i[9:0]))
    else $error("lane word not passed");
  AST_VID_TAKE: assert property (disable iff (rst_i || video_domain_reset_i)
    video_word_valid_i |=> video_word_strobe_o && video_word_o == $past(video_word_i))
    else $error("video word lost");
  AST_VRST: assert property (disable iff (rst_i)
    !FIXED_RATE_OPTION && video_domain_reset_i |=> !video_word_strobe_o)
    else $error("video strobe in reset");
  AST_AUD_TAKE: assert property (disable iff (rst_i)
    audio_data_qualifier_i |=> audio_sample_strobe_o &&
    audio_sample_o == $past(audio_sample_word_i))
    else $error("audio word lost");
  AST_AUD_HOLD: assert property (disable iff (rst_i)
    !audio_data_qualifier_i |=> !audio_sample_strobe_o && $stable(audio_sample_o))
    else $error("audio taken unqualified");
  // Main scenarios reached.
  COV_ACK: cover property (disable iff (rst_i) wb_ack_o);
  COV_AUD: cover property (disable iff (rst_i) audio_sample_strobe_o);
  COV_DDC: cover property (disable iff (rst_i) $rose(ddc_sda_oe_o));
endmodule
bind dsclk_lane_setup dsclk_lane_setup_chk #(.FIXED_RATE_OPTION(FIXED_RATE_OPTION),
  .VIDEO_BITS(VIDEO_BITS), .AUDIO_BITS(AUDIO_BITS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .video_domain_reset_i(video_domain_reset_i), .lane_word_i(lane_word_i),
  .clock_channel_out_o(clock_channel_out_o), .blue_channel_out_o(blue_channel_out_o),
  .lane_active_o(lane_active_o), .video_word_i(video_word_i),
  .video_word_valid_i(video_word_valid_i), .video_word_o(video_word_o),
  .video_word_strobe_o(video_word_strobe_o), .audio_sample_word_i(audio_sample_word_i),
  .audio_data_qualifier_i(audio_data_qualifier_i), .audio_sample_o(audio_sample_o),
  .audio_sample_strobe_o(audio_sample_strobe_o), .ddc_sda_oe_o(ddc_sda_oe_o));

// File: dv/dsclk_sink_model.sv
// Model of the data channel lines of an absent sink.
`timescale 1ns/1ps
module dsclk_sink_model (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Pull-ups hold both lines high unless the master pulls low; nobody acknowledges.
  assign scl_o = !scl_oe_i;
  assign sda_o = !sda_oe_i;
endmodule

// File: dv/testbench.sv
// Self-checking testbench of the lane setup block.
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, cyc, stb, we, vrst, vval, aq, scl, sda, ack, vs, as, soe, coe;
  logic [7:0] adr;
  logic [31:0] dat, dout, q, asw, ao;
  logic [3:0] sel, lact;
  logic [39:0] lw;
  logic [47:0] vw;
  logic [9:0] c_o, r_o, g_o, b_o;
  int n_fail, checks_done, n;
  int lane_k[4] = '{10000, 12500, 15000, 20000};
  dsclk_lane_setup u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .video_domain_reset_i(vrst), .lane_word_i(lw), .clock_channel_out_o(c_o),
    .red_channel_out_o(r_o), .green_channel_out_o(g_o), .blue_channel_out_o(b_o),
    .lane_active_o(lact), .video_word_i(vw), .video_word_valid_i(vval), .video_word_o(),
    .video_word_strobe_o(vs), .audio_sample_word_i(asw), .audio_data_qualifier_i(aq),
    .audio_sample_o(ao), .audio_sample_strobe_o(as), .ddc_scl_i(scl), .ddc_scl_o(),
    .ddc_scl_oe_o(coe), .ddc_sda_i(sda), .ddc_sda_o(), .ddc_sda_oe_o(soe));
  dsclk_sink_model u_sink (.scl_oe_i(coe), .sda_oe_i(soe), .scl_o(scl), .sda_o(sda));
  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    q = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Compares and counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads one register and compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Prints the counts and the verdict.
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  // Main sequence of tests.
  initial begin
    rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 8'h00; dat = 32'h0; sel = 4'hF; vrst = 0;
    vval = 0; aq = 0; vw = 48'h0; asw = 32'h0; lw = 40'h123456789A; n_fail = 0; checks_done = 0;
    repeat (4) @(posedge clk_i);
    chk({18'h0, lact, r_o}, 32'h0);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({12'h0, r_o, g_o}, {12'h0, lw[29:10]});
    rd(dsclk_pkg::OFS_LANE_STAT, 32'h0000000F);
    bus(1'b1, dsclk_pkg::OFS_LANE_STAT, 32'h0);
    rd(dsclk_pkg::OFS_LANE_STAT, 32'h0000000F);
    rd(8'h3C, 32'h0);
    bus(1'b1, dsclk_pkg::OFS_PIX_KHZ, 32'h000003E8);
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, dsclk_pkg::OFS_CTRL, 32'(d << 4));
      rd(dsclk_pkg::OFS_LANE_KHZ, 32'(lane_k[d]));
      rd(dsclk_pkg::OFS_LINK_KHZ, 32'(lane_k[d] / 20));
      rd(dsclk_pkg::OFS_VID_KHZ, 32'h000001F4);
    end
    bus(1'b1, dsclk_pkg::OFS_CTRL, 32'h000000C0);
    rd(dsclk_pkg::OFS_VID_KHZ, 32'h000000FA);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      vval <= i[0]; vw <= 48'(i); aq <= i[0]; asw <= 32'hA0 + i; vrst <= (i == 3);
      lw <= {4{10'(i)}};
    end
    @(posedge clk_i);
    aq <= 1'b0; vval <= 1'b0;
    rd(dsclk_pkg::OFS_LANE_STAT, 32'h0004000F);
    rd(dsclk_pkg::OFS_AUDIO, 32'h000000A7);
    bus(1'b1, dsclk_pkg::OFS_TWM_CMD, 32'h0154205A);
    n = 0;
    do begin repeat (8) @(posedge clk_i); bus(1'b0, dsclk_pkg::OFS_TWM_STAT, 32'h0); n++; end
    while (q[2] !== 1'b1 && n < 5000);
    chk(q & 32'h7, 32'h6);
    conclude();
  end
endmodule
